// ### spf_pkg.sv
// Constants, field layouts and carrier types for the strap and pin block.
// Assumes a single 250 MHz clock and the plain register port of spf_top.
//
// What this block does
// - Catch the address strap level as power-on reset releases; selects subaddress.
// - After power-on reset, drive the strap pin as transmit power sense.
// - A control bit makes power sense show active port TMDS clock present.
// - Interrupt pin is open drain: pulls low when asserted, else released.
// - Host reaches all configuration and status through the configuration serial slave; spf_top has the address-and-strobe register port instead.
// - Low on the external reset input resets; system holds it high otherwise.
// - Receiver hot-plug pin is detect output normally, control bus in mobile mode.
// - Both cable-detect/GPIO pads leave reset as inputs; software changes direction.
// - Downstream hot-plug state is sensed on a dedicated transmitter input.
// - One supply-presence input per receiver port shows source 5 V power.
// - Device is bus master on the transmitter display data channel.
package spf_pkg;

    // ***
    // Sizes
    // ***
    localparam int NUM_RX   = 3;
    localparam int NUM_GPIO = 2;
    localparam int ADDR_W   = 8;
    localparam int DATA_W   = 32;
    localparam int SYNC_W   = 2 * NUM_RX + NUM_GPIO + 4;

    // ***
    // Register byte offsets
    // ***
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h04;
    localparam logic [ADDR_W-1:0] REG_HPD    = 8'h08;
    localparam logic [ADDR_W-1:0] REG_GPIO   = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_DDC    = 8'h10;

    // ***
    // Field positions
    // ***
    localparam int ST_STRAP   = 0;
    localparam int ST_PORDONE = 1;
    localparam int ST_TXHPD   = 2;
    localparam int ST_SUPPLY  = 3;
    localparam int ST_CBUSIN  = 6;
    localparam int ST_GPIOIN  = 9;
    localparam int ST_INT     = 11;
    localparam int CT_PWRSEL  = 0;
    localparam int CT_PORT    = 1;
    localparam int CT_PWRLVL  = 3;
    localparam int HP_OUT     = 0;
    localparam int HP_MOBILE  = 3;
    localparam int HP_CBUSOUT = 6;
    localparam int HP_CBUSOE  = 9;
    localparam int GP_DIR     = 0;
    localparam int GP_OUT     = 2;
    localparam int DD_DATA    = 0;
    localparam int DD_OP      = 8;
    localparam int DD_READ    = 10;
    localparam int DD_ACK     = 11;
    localparam int DD_BUSY    = 8;
    localparam int DD_ACKIN   = 9;

    // ***
    // Reset values and timing
    // ***
    localparam logic [1:0]  CTRL_PORT_RST   = 2'h0;
    localparam logic [NUM_GPIO-1:0] GPIO_DIR_RST = 2'h0;
    localparam logic [1:0]  STRAP_SETTLE    = 2'h3;
    localparam int CLK_FREQ_KHZ = 250000;
    localparam int DDC_RATE_KHZ = 100;
    localparam int DDC_QTR_CYC  = CLK_FREQ_KHZ / (4 * DDC_RATE_KHZ);

    // ***
    // Carrier types
    // ***
    typedef enum logic [1:0] {
        DDC_NOP   = 2'b00,
        DDC_START = 2'b01,
        DDC_STOP  = 2'b10,
        DDC_XFER  = 2'b11
    } spf_ddc_op_t;

    typedef struct packed {
        logic        valid;
        spf_ddc_op_t op;
        logic        isRead;
        logic        ackOut;
        logic [7:0]  data;
    } spf_ddc_req_t;

    typedef struct packed {
        logic       busy;
        logic       ackIn;
        logic [7:0] rxData;
    } spf_ddc_rsp_t;

endpackage

// ### spf_sync.sv
// Two-flop synchroniser for a bundle of pin inputs.
// Assumes every bit is an independent level from outside the clock domain.
`timescale 1ns/10ps
module spf_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] asyncIn,
    output logic      [W-1:0] syncOut
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    // ***
    // Two stages
    // ***
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= asyncIn;
            sync_ff <= meta_ff;
        end
    end

    assign syncOut = sync_ff;

endmodule

// ### spf_ddc_master.sv
// Byte-level display data channel master: start, stop, 9-bit transfer.
// Assumes synchronised pin levels in; open-drain enables out.
`timescale 1ns/10ps
module spf_ddc_master
    import spf_pkg::*;
#(
    parameter int QTR_CYC = DDC_QTR_CYC
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire spf_ddc_req_t req,
    output spf_ddc_rsp_t      rsp,
    input  wire logic         sdaIn,
    output logic              sclOe,
    output logic              sdaOe
);

    typedef enum logic [1:0] {
        S_IDLE  = 2'b00,
        S_START = 2'b01,
        S_STOP  = 2'b10,
        S_XFER  = 2'b11
    } spf_ddc_st_t;

    spf_ddc_st_t st_ff, nxt_st;
    logic [15:0] div_ff, nxt_div;
    logic [1:0]  qtr_ff, nxt_qtr;
    logic [3:0]  bit_ff, nxt_bit;
    logic [8:0]  sh_ff, nxt_sh;
    logic        scl_ff, nxt_scl;
    logic        sda_ff, nxt_sda;
    logic        tick;

    assign tick = (div_ff == 16'(QTR_CYC - 1));

    // ***
    // Sequencer
    // ***
    always_comb begin
        nxt_st  = st_ff;
        nxt_div = tick ? 16'h0000 : div_ff + 16'h0001;
        nxt_qtr = qtr_ff;
        nxt_bit = bit_ff;
        nxt_sh  = sh_ff;
        nxt_scl = scl_ff;
        nxt_sda = sda_ff;
        unique case (st_ff)
            S_IDLE: begin
                nxt_div = 16'h0000;
                nxt_qtr = 2'h0;
                if (req.valid && req.op == DDC_START) begin
                    nxt_st = S_START;
                end else if (req.valid && req.op == DDC_STOP) begin
                    nxt_st = S_STOP;
                end else if (req.valid && req.op == DDC_XFER) begin
                    nxt_st  = S_XFER;
                    nxt_bit = 4'h0;
                    nxt_sh  = req.isRead ? {8'hff, req.ackOut}
                                         : {req.data, 1'b1};
                end
            end
            S_START: if (tick) begin
                nxt_qtr = qtr_ff + 2'h1;
                unique case (qtr_ff)
                    2'h0: begin nxt_sda = 1'b1; nxt_scl = 1'b1; end
                    2'h1: nxt_sda = 1'b0;
                    2'h2: nxt_scl = 1'b0;
                    2'h3: nxt_st  = S_IDLE;
                endcase
            end
            S_STOP: if (tick) begin
                nxt_qtr = qtr_ff + 2'h1;
                unique case (qtr_ff)
                    2'h0: begin nxt_sda = 1'b0; nxt_scl = 1'b0; end
                    2'h1: nxt_scl = 1'b1;
                    2'h2: nxt_sda = 1'b1;
                    2'h3: nxt_st  = S_IDLE;
                endcase
            end
            S_XFER: if (tick) begin
                nxt_qtr = qtr_ff + 2'h1;
                unique case (qtr_ff)
                    2'h0: begin nxt_scl = 1'b0; nxt_sda = sh_ff[8]; end
                    2'h1: nxt_scl = 1'b1;
                    2'h2: nxt_sh  = {sh_ff[7:0], sdaIn};
                    2'h3: begin
                        nxt_scl = 1'b0;
                        nxt_bit = bit_ff + 4'h1;
                        if (bit_ff == 4'h8) begin
                            nxt_st = S_IDLE;
                        end
                    end
                endcase
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_ff  <= S_IDLE;
            div_ff <= 16'h0000;
            qtr_ff <= 2'h0;
            bit_ff <= 4'h0;
            sh_ff  <= 9'h1ff;
            scl_ff <= 1'b1;
            sda_ff <= 1'b1;
        end else begin
            st_ff  <= nxt_st;
            div_ff <= nxt_div;
            qtr_ff <= nxt_qtr;
            bit_ff <= nxt_bit;
            sh_ff  <= nxt_sh;
            scl_ff <= nxt_scl;
            sda_ff <= nxt_sda;
        end
    end

    // Open drain: enable only while pulling low
    assign sclOe      = ~scl_ff;
    assign sdaOe      = ~sda_ff;
    assign rsp.busy   = (st_ff != S_IDLE);
    assign rsp.rxData = sh_ff[8:1];
    assign rsp.ackIn  = sh_ff[0];

endmodule

// ### spf_top.sv
// Strap capture, pin function control and register port of the block.
// Assumes pins arrive asynchronous; core signals share clk.
//
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/10ps
module spf_top
    import spf_pkg::*;
#(
    parameter int DDC_QTR = DDC_QTR_CYC
) (
    input  wire logic                clk,
    input  wire logic                rst_b,
    input  wire logic [ADDR_W-1:0]   regAddr,
    input  wire logic [DATA_W-1:0]   regWrData,
    input  wire logic                regWr,
    input  wire logic                regRd,
    output logic      [DATA_W-1:0]   regRdData,
    output logic                     cfgSubaddrSel,
    input  wire logic                addrStrapTxpowerPinIn,
    output logic                     addrStrapTxpowerPinOut,
    output logic                     addrStrapTxpowerPinOe,
    input  wire logic [NUM_RX-1:0]   rxTmdsClkDet,
    input  wire logic                intReq,
    output logic                     intPinOut,
    output logic                     intPinOe,
    input  wire logic [NUM_RX-1:0]   rxSupplyDetect,
    input  wire logic [NUM_RX-1:0]   rxHotplugCtrlbusPinIn,
    output logic      [NUM_RX-1:0]   rxHotplugCtrlbusPinOut,
    output logic      [NUM_RX-1:0]   rxHotplugCtrlbusPinOe,
    input  wire logic                txHotplugSense,
    input  wire logic [NUM_GPIO-1:0] cableDetectGpioIn,
    output logic      [NUM_GPIO-1:0] cableDetectGpioOut,
    output logic      [NUM_GPIO-1:0] cableDetectGpioOe,
    input  wire logic                txDdcClockIn,
    output logic                     txDdcClockOut,
    output logic                     txDdcClockOe,
    input  wire logic                txDdcDataIn,
    output logic                     txDdcDataOut,
    output logic                     txDdcDataOe
);

    // ***
    // Pin synchronisers
    // ***
    logic [SYNC_W-1:0]   syncIn;
    logic                strapS;
    logic [NUM_RX-1:0]   supplyS;
    logic [NUM_RX-1:0]   cbusS;
    logic                txHpdS;
    logic [NUM_GPIO-1:0] gpioS;
    logic                ddcDataS;
    logic                ddcClkS;

    spf_sync #(
        .W (SYNC_W)
    ) u_sync (
        .clk     (clk),
        .rst_b   (rst_b),
        .asyncIn ({addrStrapTxpowerPinIn, rxSupplyDetect,
                   rxHotplugCtrlbusPinIn, txHotplugSense,
                   cableDetectGpioIn, txDdcDataIn, txDdcClockIn}),
        .syncOut (syncIn)
    );

    assign {strapS, supplyS, cbusS, txHpdS, gpioS, ddcDataS, ddcClkS}
        = syncIn;

    // ***
    // Strap capture after reset release
    // ***
    logic [1:0] porCnt_ff, nxt_porCnt;
    logic       porDone_ff, nxt_porDone;
    logic       strap_ff, nxt_strap;

    always_comb begin
        nxt_porCnt  = porCnt_ff;
        nxt_porDone = porDone_ff;
        nxt_strap   = strap_ff;
        if (!porDone_ff) begin
            nxt_porCnt = porCnt_ff + 2'h1;
            if (porCnt_ff == STRAP_SETTLE) begin
                nxt_strap   = strapS;
                nxt_porDone = 1'b1;
            end
        end
    end

    // Latched once per reset, never re-sampled
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            porCnt_ff  <= 2'h0;
            porDone_ff <= 1'b0;
            strap_ff   <= 1'b0;
        end else begin
            porCnt_ff  <= nxt_porCnt;
            porDone_ff <= nxt_porDone;
            strap_ff   <= nxt_strap;
        end
    end

    // ***
    // Control registers
    // ***
    logic                pwrSel_ff, nxt_pwrSel;
    logic                pwrLvl_ff, nxt_pwrLvl;
    logic [1:0]          port_ff, nxt_port;
    logic [NUM_RX-1:0]   hpdOut_ff, nxt_hpdOut;
    logic [NUM_RX-1:0]   mobile_ff, nxt_mobile;
    logic [NUM_RX-1:0]   cbusOut_ff, nxt_cbusOut;
    logic [NUM_RX-1:0]   cbusOe_ff, nxt_cbusOe;
    logic [NUM_GPIO-1:0] gpioDir_ff, nxt_gpioDir;
    logic [NUM_GPIO-1:0] gpioOut_ff, nxt_gpioOut;
    spf_ddc_req_t        ddcReq;
    spf_ddc_rsp_t        ddcRsp;

    always_comb begin
        nxt_pwrSel  = pwrSel_ff;
        nxt_pwrLvl  = pwrLvl_ff;
        nxt_port    = port_ff;
        nxt_hpdOut  = hpdOut_ff;
        nxt_mobile  = mobile_ff;
        nxt_cbusOut = cbusOut_ff;
        nxt_cbusOe  = cbusOe_ff;
        nxt_gpioDir = gpioDir_ff;
        nxt_gpioOut = gpioOut_ff;
        if (regWr) begin
            unique case (regAddr)
                REG_CTRL: begin
                    nxt_pwrSel = regWrData[CT_PWRSEL];
                    nxt_pwrLvl = regWrData[CT_PWRLVL];
                    nxt_port   = regWrData[CT_PORT +: 2];
                end
                REG_HPD: begin
                    nxt_hpdOut  = regWrData[HP_OUT +: NUM_RX];
                    nxt_mobile  = regWrData[HP_MOBILE +: NUM_RX];
                    nxt_cbusOut = regWrData[HP_CBUSOUT +: NUM_RX];
                    nxt_cbusOe  = regWrData[HP_CBUSOE +: NUM_RX];
                end
                REG_GPIO: begin
                    nxt_gpioDir = regWrData[GP_DIR +: NUM_GPIO];
                    nxt_gpioOut = regWrData[GP_OUT +: NUM_GPIO];
                end
                default: begin
                    nxt_pwrSel = pwrSel_ff;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pwrSel_ff  <= 1'b0;
            pwrLvl_ff  <= 1'b0;
            port_ff    <= CTRL_PORT_RST;
            hpdOut_ff  <= '0;
            mobile_ff  <= '0;
            cbusOut_ff <= '0;
            cbusOe_ff  <= '0;
            gpioDir_ff <= GPIO_DIR_RST;
            gpioOut_ff <= '0;
        end else begin
            pwrSel_ff  <= nxt_pwrSel;
            pwrLvl_ff  <= nxt_pwrLvl;
            port_ff    <= nxt_port;
            hpdOut_ff  <= nxt_hpdOut;
            mobile_ff  <= nxt_mobile;
            cbusOut_ff <= nxt_cbusOut;
            cbusOe_ff  <= nxt_cbusOe;
            gpioDir_ff <= nxt_gpioDir;
            gpioOut_ff <= nxt_gpioOut;
        end
    end

    // ***
    // Display data channel master
    // ***
    always_comb begin
        ddcReq.valid  = regWr && (regAddr == REG_DDC) && !ddcRsp.busy;
        ddcReq.op     = spf_ddc_op_t'(regWrData[DD_OP +: 2]);
        ddcReq.isRead = regWrData[DD_READ];
        ddcReq.ackOut = regWrData[DD_ACK];
        ddcReq.data   = regWrData[DD_DATA +: 8];
    end

    spf_ddc_master #(
        .QTR_CYC (DDC_QTR)
    ) u_ddc (
        .clk   (clk),
        .rst_b (rst_b),
        .req   (ddcReq),
        .rsp   (ddcRsp),
        .sdaIn (ddcDataS),
        .sclOe (txDdcClockOe),
        .sdaOe (txDdcDataOe)
    );

    assign txDdcClockOut = 1'b0;
    assign txDdcDataOut  = 1'b0;

    // ***
    // Pin drivers
    // ***
    logic                pwrPin_ff, nxt_pwrPin;
    logic                pwrOe_ff, nxt_pwrOe;
    logic                intOe_ff, nxt_intOe;
    logic [NUM_RX-1:0]   rxOut_ff, nxt_rxOut;
    logic [NUM_RX-1:0]   rxOe_ff, nxt_rxOe;
    logic [NUM_GPIO-1:0] gpOe_ff, nxt_gpOe;

    always_comb begin
        nxt_pwrPin = pwrSel_ff ? rxTmdsClkDet[port_ff] : pwrLvl_ff;
        nxt_pwrOe  = porDone_ff;
        nxt_intOe  = intReq;
        for (int i = 0; i < NUM_RX; i++) begin
            nxt_rxOut[i] = mobile_ff[i] ? cbusOut_ff[i] : hpdOut_ff[i];
            nxt_rxOe[i]  = mobile_ff[i] ? cbusOe_ff[i] : 1'b1;
        end
        nxt_gpOe = gpioDir_ff & ~gpioOut_ff;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pwrPin_ff <= 1'b0;
            pwrOe_ff  <= 1'b0;
            intOe_ff  <= 1'b0;
            rxOut_ff  <= '0;
            rxOe_ff   <= '0;
            gpOe_ff   <= '0;
        end else begin
            pwrPin_ff <= nxt_pwrPin;
            pwrOe_ff  <= nxt_pwrOe;
            intOe_ff  <= nxt_intOe;
            rxOut_ff  <= nxt_rxOut;
            rxOe_ff   <= nxt_rxOe;
            gpOe_ff   <= nxt_gpOe;
        end
    end

    assign addrStrapTxpowerPinOut = pwrPin_ff;
    assign addrStrapTxpowerPinOe  = pwrOe_ff;
    assign cfgSubaddrSel          = strap_ff;
    assign intPinOut              = 1'b0;
    assign intPinOe               = intOe_ff;
    assign rxHotplugCtrlbusPinOut = rxOut_ff;
    assign rxHotplugCtrlbusPinOe  = rxOe_ff;
    assign cableDetectGpioOut     = '0;
    assign cableDetectGpioOe      = gpOe_ff;

    // ***
    // Read port
    // ***
    logic [DATA_W-1:0] rd_ff, nxt_rd;

    always_comb begin
        nxt_rd = '0;
        if (regRd) begin
            unique case (regAddr)
                REG_STATUS: begin
                    nxt_rd[ST_STRAP]              = strap_ff;
                    nxt_rd[ST_PORDONE]            = porDone_ff;
                    nxt_rd[ST_TXHPD]              = txHpdS;
                    nxt_rd[ST_SUPPLY +: NUM_RX]   = supplyS;
                    nxt_rd[ST_CBUSIN +: NUM_RX]   = cbusS;
                    nxt_rd[ST_GPIOIN +: NUM_GPIO] = gpioS;
                    nxt_rd[ST_INT]                = intOe_ff;
                end
                REG_CTRL: begin
                    nxt_rd[CT_PWRSEL]   = pwrSel_ff;
                    nxt_rd[CT_PORT +: 2] = port_ff;
                    nxt_rd[CT_PWRLVL]   = pwrLvl_ff;
                end
                REG_HPD: begin
                    nxt_rd[HP_OUT +: NUM_RX]     = hpdOut_ff;
                    nxt_rd[HP_MOBILE +: NUM_RX]  = mobile_ff;
                    nxt_rd[HP_CBUSOUT +: NUM_RX] = cbusOut_ff;
                    nxt_rd[HP_CBUSOE +: NUM_RX]  = cbusOe_ff;
                end
                REG_GPIO: begin
                    nxt_rd[GP_DIR +: NUM_GPIO] = gpioDir_ff;
                    nxt_rd[GP_OUT +: NUM_GPIO] = gpioOut_ff;
                end
                REG_DDC: begin
                    nxt_rd[DD_DATA +: 8] = ddcRsp.rxData;
                    nxt_rd[DD_BUSY]      = ddcRsp.busy;
                    nxt_rd[DD_ACKIN]     = ddcRsp.ackIn;
                end
                default: begin
                    nxt_rd = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_ff <= '0;
        end else begin
            rd_ff <= nxt_rd;
        end
    end

    assign regRdData = rd_ff;

endmodule

// ### spf_chk.sv
// Assertions on the ports of spf_top.
// Assumes a bind to spf_top.
`timescale 1ns/10ps
module spf_chk
    import spf_pkg::*;
(
    input wire logic                clk,
    input wire logic                rst_b,
    input wire logic [ADDR_W-1:0]   regAddr,
    input wire logic [DATA_W-1:0]   regWrData,
    input wire logic                regWr,
    input wire logic                regRd,
    input wire logic [DATA_W-1:0]   regRdData,
    input wire logic                cfgSubaddrSel,
    input wire logic                addrStrapTxpowerPinOut,
    input wire logic                addrStrapTxpowerPinOe,
    input wire logic [NUM_RX-1:0]   rxTmdsClkDet,
    input wire logic                intReq,
    input wire logic                intPinOut,
    input wire logic                intPinOe,
    input wire logic [NUM_RX-1:0]   rxHotplugCtrlbusPinOut,
    input wire logic [NUM_RX-1:0]   rxHotplugCtrlbusPinOe,
    input wire logic [NUM_GPIO-1:0] cableDetectGpioOut,
    input wire logic [NUM_GPIO-1:0] cableDetectGpioOe,
    input wire logic                txDdcClockOut,
    input wire logic                txDdcDataOut
);
    // ***
    // Shadow of written registers
    // ***
    logic [2:0]  cnt_ff;
    logic [11:0] hp_ff;
    logic [3:0]  gp_ff;
    logic [3:0]  ct_ff;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_ff <= 3'h0;
            hp_ff  <= 12'h0;
            gp_ff  <= 4'h0;
            ct_ff  <= 4'h0;
        end else begin
            if (cnt_ff != 3'h7) cnt_ff <= cnt_ff + 3'h1;
            if (regWr && regAddr == REG_HPD) hp_ff <= regWrData[11:0];
            if (regWr && regAddr == REG_GPIO) gp_ff <= regWrData[3:0];
            if (regWr && regAddr == REG_CTRL) ct_ff <= regWrData[3:0];
        end
    end

    // ***
    // Properties
    // ***
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_int_drain: assert property (intPinOut == 1'b0)
        else $error("interrupt driven high");
    a_int_delay: assert property ($past(rst_b) |-> intPinOe == $past(intReq))
        else $error("interrupt enable timing");
    a_strap_oe_time: assert property ((cnt_ff < 3'h4 || cnt_ff > 3'h5)
        |-> addrStrapTxpowerPinOe == (cnt_ff > 3'h5))
        else $error("strap drive timing");
    a_strap_hold: assert property ($past(addrStrapTxpowerPinOe)
        |-> $stable(cfgSubaddrSel))
        else $error("captured strap changed");
    a_pwr_sense: assert property ($past(addrStrapTxpowerPinOe)
        && $past(ct_ff[2:1]) != 2'h3 |-> addrStrapTxpowerPinOut ==
        $past(ct_ff[0] ? rxTmdsClkDet[ct_ff[2:1]] : ct_ff[3]))
        else $error("power sense wrong");
    a_hpd_oe: assert property ($past(rst_b) |-> rxHotplugCtrlbusPinOe ==
        $past(hp_ff[11:9] | ~hp_ff[5:3]))
        else $error("hot-plug enable wrong");
    a_hpd_out: assert property ($past(rst_b) |-> rxHotplugCtrlbusPinOut ==
        $past(hp_ff[5:3] & hp_ff[8:6] | ~hp_ff[5:3] & hp_ff[2:0]))
        else $error("hot-plug value wrong");
    a_gpio_oe: assert property ($past(rst_b) |-> cableDetectGpioOe ==
        $past(gp_ff[1:0] & ~gp_ff[3:2]))
        else $error("pad enable wrong");
    a_rd_idle: assert property (!$past(regRd) |-> regRdData == 32'h0)
        else $error("stray read data");
    a_ddc_drain: assert property (txDdcClockOut == 1'b0
        && txDdcDataOut == 1'b0 && cableDetectGpioOut == 2'h0)
        else $error("open-drain pin drives high");
endmodule

// ### spf_pin_env.sv
// Board model: pull-ups, strap source, hot-plug far ends.
// Assumes the testbench supplies the strap level and hot-plug levels.
`timescale 1ns/10ps
module spf_pin_env
    import spf_pkg::*;
(
    input wire logic                strapDrive,
    input wire logic                strapOut,
    input wire logic                strapOe,
    input wire logic                intOe,
    input wire logic [NUM_RX-1:0]   hpOut,
    input wire logic [NUM_RX-1:0]   hpOe,
    input wire logic [NUM_RX-1:0]   hpExt,
    input wire logic [NUM_GPIO-1:0] gpOe,
    input wire logic                sclOe,
    input wire logic                sdaOe,
    output logic                    strapPin,
    output logic                    intPin,
    output logic     [NUM_RX-1:0]   hpPin,
    output logic     [NUM_GPIO-1:0] gpPin,
    output logic                    sclPin,
    output logic                    sdaPin
);
    // ***
    // Wire resolution
    // ***
    assign strapPin = strapOe ? strapOut : strapDrive;
    assign intPin   = ~intOe;
    assign hpPin    = (hpOe & hpOut) | (~hpOe & hpExt);
    assign gpPin    = ~gpOe;
    assign sclPin   = ~sclOe;
    assign sdaPin   = ~sdaOe;
endmodule

// ### test_strap_and_pin_function_control.sv
// Self-checking bench for spf_top.
// Assumes spf_pin_env for the board and spf_chk bound below.
`timescale 1ns/10ps
module test_strap_and_pin_function_control
    import spf_pkg::*;
;
    logic                clk, rst_b, regWr, regRd, intReq, txHot, strapDrive;
    logic [ADDR_W-1:0]   regAddr;
    logic [DATA_W-1:0]   regWrData, regRdData, rd;
    logic [NUM_RX-1:0]   tmds, supply, hpExt, hpOut, hpOe, hpPin;
    logic [NUM_GPIO-1:0] gpOut, gpOe, gpPin;
    logic                sel, strapOut, strapOe, strapPin, intOut, intOe, intPin;
    logic                sclOut, sclOe, sclPin, sdaOut, sdaOe, sdaPin;
    int                  errTotal, nChecks;

    spf_top #(.DDC_QTR(4)) i_spf_top (.clk(clk), .rst_b(rst_b),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData(regRdData), .cfgSubaddrSel(sel),
        .addrStrapTxpowerPinIn(strapPin), .addrStrapTxpowerPinOut(strapOut),
        .addrStrapTxpowerPinOe(strapOe), .rxTmdsClkDet(tmds),
        .intReq(intReq), .intPinOut(intOut), .intPinOe(intOe),
        .rxSupplyDetect(supply), .rxHotplugCtrlbusPinIn(hpPin),
        .rxHotplugCtrlbusPinOut(hpOut), .rxHotplugCtrlbusPinOe(hpOe),
        .txHotplugSense(txHot), .cableDetectGpioIn(gpPin),
        .cableDetectGpioOut(gpOut), .cableDetectGpioOe(gpOe),
        .txDdcClockIn(sclPin), .txDdcClockOut(sclOut), .txDdcClockOe(sclOe),
        .txDdcDataIn(sdaPin), .txDdcDataOut(sdaOut), .txDdcDataOe(sdaOe));
    spf_pin_env i_spf_pin_env (.strapDrive(strapDrive), .strapOut(strapOut),
        .strapOe(strapOe), .intOe(intOe), .hpOut(hpOut), .hpOe(hpOe),
        .hpExt(hpExt), .gpOe(gpOe), .sclOe(sclOe), .sdaOe(sdaOe),
        .strapPin(strapPin), .intPin(intPin), .hpPin(hpPin), .gpPin(gpPin),
        .sclPin(sclPin), .sdaPin(sdaPin));

    // ***
    // Tasks
    // ***
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        nChecks++;
        if (seen !== exp) begin
            errTotal++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", nChecks, errTotal);
        if (errTotal == 0 && nChecks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic rdx(input logic [7:0] a);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1 rd = regRdData;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic ddc(input logic [31:0] d);
        int i;
        wr(REG_DDC, d);
        rdx(REG_DDC);
        chk("ddc busy", rd[DD_BUSY], 1'b1);
        for (i = 0; i < 300 && rd[DD_BUSY] !== 1'b0; i++) rdx(REG_DDC);
        if (i == 300) begin
            errTotal++;
            end_sim();
        end
    endtask

    // ***
    // Stimulus
    // ***
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        {rst_b, regWr, regRd, intReq, txHot, regAddr, regWrData} = '0;
        {strapDrive, tmds, supply, hpExt} = 10'h342;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        cyc(8);
        chk("subaddr", sel, 1'b1);
        chk("strap oe", strapOe, 1'b1);
        strapDrive <= 1'b0;
        wr(REG_CTRL, 32'h0);
        cyc(4);
        chk("subaddr held", sel, 1'b1);
        chk("sense low", strapPin, 1'b0);
        for (int p = 0; p < 3; p++) begin
            wr(REG_CTRL, 32'(p * 2 + 1));
            cyc(3);
            chk("sense clk", strapPin, tmds[p]);
        end
        wr(REG_CTRL, 32'h8);
        cyc(3);
        chk("sense high", strapPin, 1'b1);
        @(posedge clk);
        txHot <= 1'b1;
        supply <= 3'b101;
        intReq <= 1'b1;
        cyc(4);
        chk("int pin", intPin, 1'b0);
        rdx(REG_STATUS);
        chk("tx hotplug", rd[ST_TXHPD], 1'b1);
        chk("supply", rd[5:3], 3'b101);
        chk("int flag", rd[ST_INT], 1'b1);
        @(posedge clk);
        intReq <= 1'b0;
        cyc(2);
        chk("int release", intPin, 1'b1);
        wr(REG_HPD, 32'h415);
        cyc(2);
        chk("hpd mobile", hpPin, 3'b101);
        wr(REG_HPD, 32'h015);
        cyc(4);
        chk("cbus release", hpPin, 3'b111);
        rdx(REG_GPIO);
        chk("gpio reset", rd, 32'h0);
        chk("gpio pins", gpPin, 2'b11);
        wr(REG_GPIO, 32'h1);
        cyc(4);
        chk("gpio drive", gpPin, 2'b10);
        rdx(REG_STATUS);
        chk("gpio status", rd[10:9], 2'b10);
        wr(8'h14, 32'hffff);
        rdx(8'h14);
        chk("unmapped", rd, 32'h0);
        rdx(REG_CTRL);
        chk("ctrl back", rd[3:0], 4'h8);
        ddc(32'h100);
        chk("start lines", {sclPin, sdaPin}, 2'b00);
        ddc(32'h3a5);
        chk("no ack", rd[DD_ACKIN], 1'b1);
        ddc(32'h200);
        chk("stop lines", {sclPin, sdaPin}, 2'b11);
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        cyc(8);
        chk("subaddr low", sel, 1'b0);
        chk("hpd reset", hpPin, 3'b000);
        chk("gpio input", gpPin, 2'b11);
        end_sim();
    end
endmodule

bind spf_top spf_chk i_spf_chk (.*);
